//--- design/smic_arbiter.sv
// Fixed-slot memory arbiter with a refresh requester.
// Assumes slot fields and requests are stable within the cycle.
`timescale 1ns/1ps
module smic_arbiter (
  // Priority slots, slot 1 in the low bits
  input wire logic [7:0] slots_i,
  // Requests
  input wire logic [3:0] req_i,
  input wire logic refresh_req_i,
  input wire logic refresh_urgent_i,
  // One-hot winner, bit 4 is refresh
  output logic [4:0] win_o
);
  function automatic logic [3:0] ent_onehot(input logic [1:0] ent);
    ent_onehot = 4'h1 << ent;
  endfunction : ent_onehot

  always_comb begin
    logic found;
    logic [3:0] sel;
    found = 1'b0;
    sel = 4'h0;
    win_o = 5'h00;
    if (refresh_req_i && refresh_urgent_i) begin
      win_o = 5'h10;
      found = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      sel = ent_onehot(slots_i[2*i +: 2]);
      if (!found && |(sel & req_i)) begin
        win_o = {1'b0, sel};
        found = 1'b1;
      end
    end
    if (!found && refresh_req_i) begin
      win_o = 5'h10;
    end
  end
endmodule : smic_arbiter

//--- design/smic_params.svh
// Constants of the shared memory interface configuration block.
// Included by the package user files; definitions only.
`ifndef SMIC_PARAMS_SVH
`define SMIC_PARAMS_SVH

// Clock and rounding of times to whole cycles
`define SMIC_CLK_PERIOD_NS 25
`define SMIC_NS_TO_CYC(ns) (((ns) + `SMIC_CLK_PERIOD_NS - 1) / `SMIC_CLK_PERIOD_NS)

// Strobe phase times
`define SMIC_T_SHORT_NS 30
`define SMIC_T_LONG_NS 60
`define SMIC_T_EDGE_NS 15
`define SMIC_T_RD_TAIL_NS 30
`define SMIC_T_PULSE_STEP_NS 30
`define SMIC_T_HIZ_NS 15
`define SMIC_CYC_SHORT `SMIC_NS_TO_CYC(`SMIC_T_SHORT_NS)
`define SMIC_CYC_LONG `SMIC_NS_TO_CYC(`SMIC_T_LONG_NS)
`define SMIC_CYC_EDGE `SMIC_NS_TO_CYC(`SMIC_T_EDGE_NS)
`define SMIC_CYC_RD_TAIL `SMIC_NS_TO_CYC(`SMIC_T_RD_TAIL_NS)
`define SMIC_CYC_HIZ `SMIC_NS_TO_CYC(`SMIC_T_HIZ_NS)

// Refresh spacing in crystal periods
`define SMIC_REFRESH_XTAL_PERIODS 512
`define SMIC_REFRESH_HALF_PERIODS (`SMIC_REFRESH_XTAL_PERIODS / 2)
`define SMIC_ROWS_DRAM_256K 512
`define SMIC_ROWS_DRAM_1M 1024
`define SMIC_ROWS_DRAM_4M 2048

// Register indices, byte addresses and reset values
`define SMIC_IDX_MEM_CFG 12'h032
`define SMIC_IDX_IB_BASE 12'h034
`define SMIC_IDX_IQ_SIZE 12'h036
`define SMIC_ADDR_MEM_CFG (`SMIC_IDX_MEM_CFG * 12'h004)
`define SMIC_ADDR_IB_BASE (`SMIC_IDX_IB_BASE * 12'h004)
`define SMIC_ADDR_IQ_SIZE (`SMIC_IDX_IQ_SIZE * 12'h004)
`define SMIC_ADDR_STATUS 12'h100
`define SMIC_RST_MEM_CFG 16'hE4F0
`define SMIC_RST_IB_BASE 16'h0000
`define SMIC_RST_IQ_SIZE 16'h0000

// Memory configuration fields
`define SMIC_F_REF 0
`define SMIC_F_ORG_LO 1
`define SMIC_F_ORG_HI 3
`define SMIC_F_U 4
`define SMIC_F_V 5
`define SMIC_F_W 6
`define SMIC_F_Z 7
`define SMIC_F_SLOT_LO 8
`define SMIC_F_SLOT_HI 15

// Queue size fields
`define SMIC_F_CS_LO 0
`define SMIC_F_CS_HI 1
`define SMIC_F_MS_LO 2
`define SMIC_F_MS_HI 4
`define SMIC_F_HS_LO 5
`define SMIC_F_HS_HI 7
`define SMIC_F_TIME_BASE_SELECT 15

// Shared memory layout
`define SMIC_IB_SHIFT 8
`define SMIC_QUEUE_OFFSET 256
`define SMIC_BIG_Q_UNIT 128
`define SMIC_CI_Q_UNIT 64

// Bus responses
`define SMIC_RESP_OKAY 2'h0
`define SMIC_RESP_SLVERR 2'h2

`endif

//--- design/smic_pkg.sv
// Types of the shared memory interface configuration block.
// Constants live in smic_params.svh.
package smic_pkg;

  typedef enum logic [2:0] {
    SMIC_ORG_SRAM_128K = 3'b000,
    SMIC_ORG_SRAM_512K = 3'b001,
    SMIC_ORG_DRAM_256K = 3'b010,
    SMIC_ORG_DRAM_1M = 3'b011,
    SMIC_ORG_DRAM_4M = 3'b100
  } smic_org_t;

  typedef enum logic [2:0] {
    SMIC_ST_IDLE = 3'b000,
    SMIC_ST_PH1 = 3'b001,
    SMIC_ST_PH2 = 3'b010,
    SMIC_ST_PH3 = 3'b011,
    SMIC_ST_PH4 = 3'b100
  } smic_state_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } smic_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } smic_axil_rsp_t;

  typedef struct packed {
    logic row_strobe_n;
    logic column_strobe_n;
    logic chip_enable_n;
    logic output_enable_n;
    logic write_enable_n;
    logic bus_drive;
  } smic_strobe_t;

  typedef struct packed {
    logic [23:0] ib_base;
    logic [22:0] ib_word;
    logic [23:0] hdlc_base;
    logic [10:0] hdlc_words;
    logic [23:0] mon_base;
    logic [10:0] mon_words;
    logic [23:0] ci_base;
    logic [8:0] ci_words;
  } smic_queue_map_t;

endpackage : smic_pkg

//--- design/smic_top.sv
// Shared memory interface configuration: registers, refresh, arbitration, strobe timing.
// Assumes synchronous inputs, requesters holding req until granted, and an AXI4-Lite master.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "smic_params.svh"

// Functional notes
// - Refresh runs only while the refresh enable bit is one.
// - One refresh cycle starts every 512 crystal clock periods.
// - Organisation code 0..4 picks SRAM or DRAM type; codes 5..7 are forbidden.
// - Refresh rows per DRAM type: 512, 1024 or 2048.
// - DRAM row and column strobe fall delays are 60ns or 30ns per bit.
// - DRAM column low and tail are 60ns or 30ns; cycle sums four phases.
// - Memory outputs float during the last 15ns of every cycle.
// - Between cycles outputs float or drive per the low-impedance select.
// - SRAM write chip enable pulse 30..120ns, plus 15ns either side.
// - SRAM read output enable pulse 30..120ns, plus 30ns.
// - Four two-bit slots name requesters; slot one wins first.
// - Refresh normally ranks last, below all four requesters.
// - Refresh unserved after half an interval jumps to top rank.
// - Configuration register resets to E4F0.
// - Initiate block base is register value times 256.
// - Upper 23 address bits pick a word; low bit picks a byte.
// - HDLC queue starts at base plus 256, 128 words times code plus one.
// - Monitor queue follows HDLC queue, same size scale.
// - Command/indicate queue follows monitor queue, 64 to 256 words.
// - Time base ticks on frame sync rise or on every master clock.
module smic_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Register bus
  input wire smic_pkg::smic_axil_req_t axil_req_i,
  output smic_pkg::smic_axil_rsp_t axil_rsp_o,
  // Timing sources
  input wire logic crystal_input_i,
  input wire logic frame_sync_i,
  input wire logic bus_low_z_select_i,
  // Requesters: rx dma, processor, tx dma, interrupt controller
  input wire logic [3:0] mem_req_i,
  input wire logic [3:0] mem_we_i,
  output logic [3:0] mem_grant_o,
  output logic refresh_active_o,
  output logic cycle_done_o,
  // Memory strobes and refresh row
  output smic_pkg::smic_strobe_t strobe_o,
  output logic [10:0] refresh_row_o,
  // Shared memory layout and time base
  output smic_pkg::smic_queue_map_t queue_map_o,
  output logic time_base_tick_o
);
  import smic_pkg::*;

  logic [15:0] mem_cfg;
  logic [15:0] ib_base;
  logic [15:0] iq_size;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [15:0] w_data;
  logic [1:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic do_write;
  logic [2:0] wsel;
  logic [15:0] cfg_wr;
  smic_org_t org;
  logic is_dram;
  logic refresh_on;
  logic xtal_q;
  logic xtal_rise;
  logic [8:0] xtal_cnt;
  logic interval_start;
  logic half_hit;
  logic refresh_pend;
  logic refresh_urgent;
  logic refresh_grant;
  logic [10:0] refresh_row;
  logic [10:0] row_last;
  logic [4:0] win;
  smic_state_t state;
  smic_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [4:0] owner;
  logic [4:0] next_owner;
  logic cyc_wr;
  logic next_wr;
  logic start;
  logic cycle_end;
  logic fs_q;

  // Register decode: bit 2 hit, bits 1:0 select
  function automatic logic [2:0] reg_decode(input logic [11:0] addr);
    if (addr == `SMIC_ADDR_MEM_CFG) reg_decode = 3'h4;
    else if (addr == `SMIC_ADDR_IB_BASE) reg_decode = 3'h5;
    else if (addr == `SMIC_ADDR_IQ_SIZE) reg_decode = 3'h6;
    else if (addr == `SMIC_ADDR_STATUS) reg_decode = 3'h7;
    else reg_decode = 3'h0;
  endfunction : reg_decode

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic last_phase(input smic_state_t st, input logic dram);
    last_phase = (st == SMIC_ST_PH4) || (!dram && st == SMIC_ST_PH3);
  endfunction : last_phase

  function automatic logic [3:0] phase_len(input smic_state_t st, input logic dram,
                                           input logic wr, input logic [15:0] cfg);
    int code;
    code = 0;
    phase_len = 4'(`SMIC_CYC_SHORT);
    if (dram) begin
      unique case (st)
        SMIC_ST_PH1: phase_len = cfg[`SMIC_F_U] ? 4'(`SMIC_CYC_LONG) : 4'(`SMIC_CYC_SHORT);
        SMIC_ST_PH2: phase_len = cfg[`SMIC_F_V] ? 4'(`SMIC_CYC_LONG) : 4'(`SMIC_CYC_SHORT);
        SMIC_ST_PH3: phase_len = cfg[`SMIC_F_W] ? 4'(`SMIC_CYC_LONG) : 4'(`SMIC_CYC_SHORT);
        default: phase_len = cfg[`SMIC_F_Z] ? 4'(`SMIC_CYC_LONG) : 4'(`SMIC_CYC_SHORT);
      endcase
    end else if (st == SMIC_ST_PH2) begin
      code = wr ? int'({cfg[`SMIC_F_V], cfg[`SMIC_F_U]}) : int'({cfg[`SMIC_F_Z], cfg[`SMIC_F_W]});
      phase_len = 4'(`SMIC_NS_TO_CYC(`SMIC_T_PULSE_STEP_NS * (code + 1)));
    end else if (st == SMIC_ST_PH3 && !wr) begin
      phase_len = 4'(`SMIC_CYC_RD_TAIL);
    end else begin
      phase_len = 4'(`SMIC_CYC_EDGE);
    end
  endfunction : phase_len

  function automatic smic_strobe_t strobe_of(input smic_state_t st, input logic [3:0] c,
                                             input logic dram, input logic wr, input logic refr,
                                             input logic low_z);
    smic_strobe_t s;
    s = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, low_z};
    if (st != SMIC_ST_IDLE) begin
      s.bus_drive = !(last_phase(st, dram) && c <= 4'(`SMIC_CYC_HIZ));
      if (dram) begin
        s.row_strobe_n = (st == SMIC_ST_PH1);
        s.column_strobe_n = !(st == SMIC_ST_PH3 && !refr);
        s.output_enable_n = !(st == SMIC_ST_PH3 && !wr && !refr);
        s.write_enable_n = !((st == SMIC_ST_PH2 || st == SMIC_ST_PH3) && wr && !refr);
      end else begin
        s.chip_enable_n = (st != SMIC_ST_PH2);
        s.output_enable_n = !(st == SMIC_ST_PH2 && !wr);
        s.write_enable_n = !(st == SMIC_ST_PH2 && wr);
      end
    end
    strobe_of = s;
  endfunction : strobe_of

  // Register bus slave
  assign do_write = aw_held && w_held && !bvalid;
  assign wsel = reg_decode(aw_addr);
  always_comb begin
    cfg_wr = merge16(mem_cfg, w_data, w_strb);
    if (cfg_wr[`SMIC_F_ORG_HI:`SMIC_F_ORG_LO] > 3'h4) begin
      cfg_wr[`SMIC_F_ORG_HI:`SMIC_F_ORG_LO] = mem_cfg[`SMIC_F_ORG_HI:`SMIC_F_ORG_LO];
    end
  end

  always_comb begin
    axil_rsp_o.awready = ce_i && !aw_held && !bvalid;
    axil_rsp_o.wready = ce_i && !w_held && !bvalid;
    axil_rsp_o.bvalid = bvalid;
    axil_rsp_o.bresp = bresp;
    axil_rsp_o.arready = ce_i && !rvalid;
    axil_rsp_o.rvalid = rvalid;
    axil_rsp_o.rdata = rdata;
    axil_rsp_o.rresp = rresp;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
      bvalid <= 1'b0;
      bresp <= `SMIC_RESP_OKAY;
    end else if (ce_i) begin
      if (axil_req_i.awvalid && axil_rsp_o.awready) begin
        aw_held <= 1'b1;
        aw_addr <= axil_req_i.awaddr;
      end
      if (axil_req_i.wvalid && axil_rsp_o.wready) begin
        w_held <= 1'b1;
        w_data <= axil_req_i.wdata[15:0];
        w_strb <= axil_req_i.wstrb[1:0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wsel[2] ? `SMIC_RESP_OKAY : `SMIC_RESP_SLVERR;
      end else if (bvalid && axil_req_i.bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_cfg <= `SMIC_RST_MEM_CFG;
      ib_base <= `SMIC_RST_IB_BASE;
      iq_size <= `SMIC_RST_IQ_SIZE;
    end else if (ce_i && do_write) begin
      unique case (wsel)
        3'h4: mem_cfg <= cfg_wr;
        3'h5: ib_base <= merge16(ib_base, w_data, w_strb);
        3'h6: iq_size <= merge16(iq_size, w_data, w_strb);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `SMIC_RESP_OKAY;
    end else if (ce_i) begin
      if (axil_req_i.arvalid && axil_rsp_o.arready) begin
        rvalid <= 1'b1;
        rresp <= `SMIC_RESP_OKAY;
        unique case (reg_decode(axil_req_i.araddr))
          3'h4: rdata <= {16'h0000, mem_cfg};
          3'h5: rdata <= {16'h0000, ib_base};
          3'h6: rdata <= {16'h0000, iq_size};
          3'h7: rdata <= {11'h000, owner, state, refresh_urgent, refresh_pend, refresh_row};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `SMIC_RESP_SLVERR;
          end
        endcase
      end else if (rvalid && axil_req_i.rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Refresh scheduling
  assign org = smic_org_t'(mem_cfg[`SMIC_F_ORG_HI:`SMIC_F_ORG_LO]);
  assign is_dram = (org == SMIC_ORG_DRAM_256K) || (org == SMIC_ORG_DRAM_1M) || (org == SMIC_ORG_DRAM_4M);
  assign refresh_on = mem_cfg[`SMIC_F_REF] && is_dram;
  assign xtal_rise = crystal_input_i && !xtal_q;
  assign interval_start = refresh_on && xtal_rise && (xtal_cnt == 9'(`SMIC_REFRESH_XTAL_PERIODS - 1));
  assign half_hit = refresh_on && xtal_rise && (xtal_cnt == 9'(`SMIC_REFRESH_HALF_PERIODS - 1));
  assign refresh_grant = ce_i && start && win[4];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      xtal_q <= 1'b0;
      xtal_cnt <= 9'h000;
    end else if (ce_i) begin
      xtal_q <= crystal_input_i;
      if (!refresh_on) xtal_cnt <= 9'h000;
      else if (xtal_rise) xtal_cnt <= xtal_cnt + 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      refresh_pend <= 1'b0;
      refresh_urgent <= 1'b0;
    end else if (ce_i) begin
      if (!refresh_on) begin
        refresh_pend <= 1'b0;
        refresh_urgent <= 1'b0;
      end else begin
        refresh_pend <= interval_start || (refresh_pend && !refresh_grant);
        refresh_urgent <= (half_hit && refresh_pend && !refresh_grant) || (refresh_urgent && !refresh_grant);
      end
    end
  end

  always_comb begin
    unique case (org)
      SMIC_ORG_DRAM_256K: row_last = 11'(`SMIC_ROWS_DRAM_256K - 1);
      SMIC_ORG_DRAM_1M: row_last = 11'(`SMIC_ROWS_DRAM_1M - 1);
      default: row_last = 11'(`SMIC_ROWS_DRAM_4M - 1);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      refresh_row <= 11'h000;
    end else if (ce_i && refresh_grant) begin
      refresh_row <= (refresh_row >= row_last) ? 11'h000 : refresh_row + 11'h001;
    end
  end

  // Arbitration and cycle sequencing
  smic_arbiter u_arbiter (
    .slots_i(mem_cfg[`SMIC_F_SLOT_HI:`SMIC_F_SLOT_LO]),
    .req_i(mem_req_i),
    .refresh_req_i(refresh_pend && refresh_on),
    .refresh_urgent_i(refresh_urgent),
    .win_o(win)
  );

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_owner = owner;
    next_wr = cyc_wr;
    start = 1'b0;
    cycle_end = 1'b0;
    unique case (state)
      SMIC_ST_IDLE: begin
        if (|win) begin
          start = 1'b1;
          next_owner = win;
          next_wr = |(win[3:0] & mem_we_i);
          next_state = (is_dram || next_wr) ? SMIC_ST_PH1 : SMIC_ST_PH2;
          next_cnt = phase_len(next_state, is_dram, next_wr, mem_cfg);
        end
      end
      SMIC_ST_PH1, SMIC_ST_PH2, SMIC_ST_PH3, SMIC_ST_PH4: begin
        if (cnt > 4'h1) begin
          next_cnt = cnt - 4'h1;
        end else if (last_phase(state, is_dram)) begin
          next_state = SMIC_ST_IDLE;
          next_owner = 5'h00;
          cycle_end = 1'b1;
        end else begin
          next_state = smic_state_t'(state + 3'h1);
          next_cnt = phase_len(next_state, is_dram, cyc_wr, mem_cfg);
        end
      end
      default: begin
        next_state = SMIC_ST_IDLE;
        next_owner = 5'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= SMIC_ST_IDLE;
      cnt <= 4'h0;
      owner <= 5'h00;
      cyc_wr <= 1'b0;
      cycle_done_o <= 1'b0;
      strobe_o <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end else if (ce_i) begin
      state <= next_state;
      cnt <= next_cnt;
      owner <= next_owner;
      cyc_wr <= next_wr;
      cycle_done_o <= cycle_end;
      strobe_o <= strobe_of(next_state, next_cnt, is_dram, next_wr, next_owner[4], bus_low_z_select_i);
    end
  end

  assign mem_grant_o = owner[3:0];
  assign refresh_active_o = owner[4];
  assign refresh_row_o = refresh_row;

  // Shared memory layout and time base
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      queue_map_o <= '0;
      fs_q <= 1'b0;
      time_base_tick_o <= 1'b0;
    end else if (ce_i) begin
      queue_map_o.ib_base <= {ib_base, 8'h00};
      queue_map_o.ib_word <= {ib_base, 7'h00};
      queue_map_o.hdlc_base <= {ib_base, 8'h00} + 24'(`SMIC_QUEUE_OFFSET);
      queue_map_o.hdlc_words <= 11'((iq_size[`SMIC_F_HS_HI:`SMIC_F_HS_LO] + 4'h1) * `SMIC_BIG_Q_UNIT);
      queue_map_o.mon_base <= {ib_base, 8'h00} + 24'(`SMIC_QUEUE_OFFSET)
        + 24'((iq_size[`SMIC_F_HS_HI:`SMIC_F_HS_LO] + 4'h1) * `SMIC_BIG_Q_UNIT);
      queue_map_o.mon_words <= 11'((iq_size[`SMIC_F_MS_HI:`SMIC_F_MS_LO] + 4'h1) * `SMIC_BIG_Q_UNIT);
      queue_map_o.ci_base <= {ib_base, 8'h00} + 24'(`SMIC_QUEUE_OFFSET)
        + 24'((iq_size[`SMIC_F_HS_HI:`SMIC_F_HS_LO] + 4'h1) * `SMIC_BIG_Q_UNIT)
        + 24'((iq_size[`SMIC_F_MS_HI:`SMIC_F_MS_LO] + 4'h1) * `SMIC_BIG_Q_UNIT);
      queue_map_o.ci_words <= 9'((iq_size[`SMIC_F_CS_HI:`SMIC_F_CS_LO] + 3'h1) * `SMIC_CI_Q_UNIT);
      fs_q <= frame_sync_i;
      time_base_tick_o <= iq_size[`SMIC_F_TIME_BASE_SELECT] ? (frame_sync_i && !fs_q) : 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);

  property p_refresh_off;
    !mem_cfg[`SMIC_F_REF] |=> !refresh_pend && !$rose(refresh_active_o);
  endproperty
  a_refresh_off: assert property (p_refresh_off) else $error("refresh active while disabled");

  property p_interval;
    interval_start |=> refresh_pend;
  endproperty
  a_interval: assert property (p_interval) else $error("refresh not requested at interval");

  property p_bad_org;
    do_write && wsel == 3'h4 && w_strb[0] && w_data[3:1] > 3'h4 |=> $stable(org);
  endproperty
  a_bad_org: assert property (p_bad_org) else $error("forbidden organisation stored");

  property p_dram_u_short;
    start && is_dram && !mem_cfg[`SMIC_F_U] ##1 $stable(mem_cfg) |-> state == SMIC_ST_PH1 [*2] ##1
      state == SMIC_ST_PH2;
  endproperty
  a_dram_u_short: assert property (p_dram_u_short) else $error("short row delay wrong");

  property p_hiz_end;
    state != SMIC_ST_IDLE && last_phase(state, is_dram) && cnt == 4'h1 |-> !strobe_o.bus_drive;
  endproperty
  a_hiz_end: assert property (p_hiz_end) else $error("bus driven in last cycle");

  property p_idle_drive;
    state == SMIC_ST_IDLE && $past(state) == SMIC_ST_IDLE && $past(ce_i) && !$past(sys_rst_i)
      |-> strobe_o.bus_drive == $past(bus_low_z_select_i);
  endproperty
  a_idle_drive: assert property (p_idle_drive) else $error("idle drive mismatch");

  property p_refresh_last;
    state == SMIC_ST_IDLE && |mem_req_i && refresh_pend && !refresh_urgent |=> !refresh_active_o;
  endproperty
  a_refresh_last: assert property (p_refresh_last) else $error("refresh beat a requester");

  property p_refresh_urgent;
    state == SMIC_ST_IDLE && refresh_on && refresh_pend && refresh_urgent |=> refresh_active_o;
  endproperty
  a_refresh_urgent: assert property (p_refresh_urgent) else $error("urgent refresh not granted");

  property p_reset_value;
    $past(sys_rst_i) && !sys_rst_i |-> mem_cfg == `SMIC_RST_MEM_CFG;
  endproperty
  a_reset_value: assert property (disable iff (1'b0) p_reset_value) else $error("bad reset value");

  property p_one_owner;
    $onehot0(owner) && (state == SMIC_ST_IDLE || owner != 5'h00);
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("grant not exclusive");

  c_urgent_refresh: cover property (start && win[4] && refresh_urgent);
  c_sram_write: cover property (start && !is_dram && next_wr);
  c_dram_read: cover property (start && is_dram && !next_wr && !win[4]);
  c_reg_write: cover property (do_write && wsel == 3'h4);
endmodule : smic_top

//--- sim/smic_ram_model.sv
// External DRAM/SRAM stand-in: measures column strobe low width.
// Assumes the strobes come straight from the controller, one clock domain.
`timescale 1ns/1ps
module smic_ram_model import smic_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Controller strobes
  input wire smic_strobe_t strobe_i,
  // Last column strobe low width in clocks
  output logic [7:0] cas_low_o
);
  logic [7:0] cnt;
  // Width of each column strobe pulse
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt <= 8'h00;
      cas_low_o <= 8'h00;
    end else if (!strobe_i.column_strobe_n) begin
      cnt <= cnt + 8'h01;
    end else begin
      if (cnt != 8'h00) cas_low_o <= cnt;
      cnt <= 8'h00;
    end
  end
endmodule : smic_ram_model

//--- sim/tb_top.sv
// Testbench of the shared memory configuration block.
// Registers over AXI4-Lite, memory requests, RAM model on the strobes.
`timescale 1ns/1ps
`include "smic_params.svh"
module tb_top;
  import smic_pkg::*;
  logic clk_i = 0;
  logic sys_rst_i = 1;
  logic xtal = 0;
  logic [3:0] mem_req = 4'h0;
  logic [3:0] mem_we = 4'h0;
  logic ref_act;
  logic [10:0] row;
  smic_axil_req_t req = '0;
  smic_axil_rsp_t rsp;
  logic [3:0] grant;
  logic done;
  smic_strobe_t strobe;
  smic_queue_map_t qmap;
  logic tick;
  logic [7:0] cas_low;
  int bad_count = 0;
  int cmp_count = 0;
  always #12.5 clk_i = ~clk_i;
  always #50 xtal = ~xtal;
  smic_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .axil_req_i(req), .axil_rsp_o(rsp),
    .crystal_input_i(xtal), .frame_sync_i(1'b0), .bus_low_z_select_i(1'b1), .mem_req_i(mem_req),
    .mem_we_i(mem_we), .mem_grant_o(grant), .refresh_active_o(ref_act), .cycle_done_o(done), .strobe_o(strobe),
    .refresh_row_o(row), .queue_map_o(qmap), .time_base_tick_o(tick));
  smic_ram_model ram_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .strobe_i(strobe), .cas_low_o(cas_low));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic aw;
    logic w;
    aw = 1;
    w = 1;
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {16'h0000, d}, wstrb: 4'hF, bready: 1'b1, default: '0};
    while (aw || w) begin
      @(posedge clk_i);
      if (aw && rsp.awready === 1'b1) begin
        aw = 0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 0;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge clk_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_i); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(`SMIC_ADDR_MEM_CFG, d, r);
    chk("cfg", d, 32'h0000E4F0);
    rd(`SMIC_ADDR_IQ_SIZE, d, r);
    chk("iq", d, 32'h00000000);
    chk("idle drive", strobe.bus_drive, 32'h1);
    chk("tick", tick, 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_map;
    wr(`SMIC_ADDR_IB_BASE, 16'h0100);
    wr(`SMIC_ADDR_IQ_SIZE, 16'h002B);
    repeat (3) @(posedge clk_i);
    chk("ib base", qmap.ib_base, 32'h00010000);
    chk("ib word", qmap.ib_word, 32'h00008000);
    chk("hdlc base", qmap.hdlc_base, 32'h00010100);
    chk("hdlc words", qmap.hdlc_words, 32'h00000100);
    chk("mon base", qmap.mon_base, 32'h00010200);
    chk("mon words", qmap.mon_words, 32'h00000180);
    chk("ci base", qmap.ci_base, 32'h00010380);
    chk("ci words", qmap.ci_words, 32'h00000100);
    $display("map test done");
  endtask : t_map
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    rd(12'h0FC, d, r);
    chk("unmapped resp", r, 32'h2);
    chk("unmapped data", d, 32'h0);
    wr(`SMIC_ADDR_MEM_CFG, 16'hE4FA);
    rd(`SMIC_ADDR_MEM_CFG, d, r);
    chk("forbidden org", d, 32'h0000E4F0);
    $display("bus test done");
  endtask : t_bus
  task automatic t_arb;
    wr(`SMIC_ADDR_MEM_CFG, 16'hE444);
    mem_req <= 4'hF;
    do @(posedge clk_i); while (grant === 4'h0);
    chk("first grant", grant, 32'h1);
    mem_req <= 4'hE;
    do @(posedge clk_i); while (done !== 1'b1);
    chk("cas low", cas_low, 32'h3);
    do @(posedge clk_i); while (grant === 4'h0);
    chk("second grant", grant, 32'h2);
    mem_req <= 4'h0;
    do @(posedge clk_i); while (done !== 1'b1);
    $display("arbiter test done");
  endtask : t_arb
  task automatic t_sram;
    int n;
    int m;
    n = 0;
    m = 0;
    wr(`SMIC_ADDR_MEM_CFG, 16'hE410);
    mem_we <= 4'h2;
    mem_req <= 4'h2;
    do @(posedge clk_i); while (grant === 4'h0);
    mem_req <= 4'h0;
    while (grant !== 4'h0) begin
      if (strobe.chip_enable_n === 1'b0) m++;
      @(posedge clk_i);
      n++;
    end
    chk("sram ce low", m, 32'h3);
    chk("sram cycle", n, 32'h5);
    mem_we <= 4'h0;
    $display("sram test done");
  endtask : t_sram
  task automatic wait_ref(input int lim, output int n);
    logic was;
    n = 0;
    do begin
      was = ref_act;
      @(posedge clk_i);
      n++;
    end while (!(ref_act === 1'b1 && was !== 1'b1) && n < lim);
  endtask : wait_ref
  task automatic t_refresh;
    int n;
    wr(`SMIC_ADDR_MEM_CFG, 16'hE445);
    mem_req <= 4'h1;
    wait_ref(4000, n);
    chk("urgent wait", 32'(n >= 3060 && n <= 3090), 32'h1);
    chk("refresh row", row, 32'h1);
    mem_req <= 4'h0;
    wait_ref(1500, n);
    wait_ref(2500, n);
    chk("refresh spacing", n, 32'h00000800);
    wr(`SMIC_ADDR_MEM_CFG, 16'hE444);
    wait_ref(2200, n);
    chk("refresh off", ref_act, 32'h0);
    $display("refresh test done");
  endtask : t_refresh
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_map();
    t_bus();
    t_arb();
    t_sram();
    t_refresh();
    print_verdict();
  end
endmodule : tb_top
